// *** include/tcsf_cfg.svh ***
`ifndef TCSF_CFG_SVH
`define TCSF_CFG_SVH

// register offsets on the byte bus
`define TCSF_OFS_CTRL   8'h12
`define TCSF_OFS_STAT   8'h13
`define TCSF_OFS_CAPH   8'h14
`define TCSF_OFS_CAPL   8'h15
`define TCSF_OFS_CMPH   8'h16
`define TCSF_OFS_CMPL   8'h17
`define TCSF_OFS_CNTH   8'h18
`define TCSF_OFS_CNTL   8'h19
`define TCSF_OFS_ALTH   8'h1a
`define TCSF_OFS_ALTL   8'h1b

// control field positions
`define TCSF_BIT_CAP_IE 7
`define TCSF_BIT_CMP_IE 6
`define TCSF_BIT_OVF_IE 5
`define TCSF_BIT_EDGE   1
`define TCSF_BIT_LEVEL  0

// status field positions
`define TCSF_BIT_CAP_F  7
`define TCSF_BIT_CMP_F  6
`define TCSF_BIT_OVF_F  5

// reset values and masks
`define TCSF_CTRL_RESET 8'h01
`define TCSF_CTRL_MASK  8'he3
`define TCSF_CNT_RESET  16'hfffc
`define TCSF_CNT_MAX    16'hffff

// bus clocks per counter step
`define TCSF_PRESCALE   4

`endif

// *** include/tcsf_pkg.sv ***
package tcsf_pkg;

    // timer state within one prescaler period
    typedef enum logic [1:0] {
        TCSF_T00 = 2'b00,
        TCSF_T01 = 2'b01,
        TCSF_T10 = 2'b10,
        TCSF_T11 = 2'b11
    } tcsf_phase_t;

    // one bus request, strobes one cycle wide
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tcsf_bus_req_t;

    // synchroniser and edge detector state
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } tcsf_sync_t;

    // main timer state
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [15:0] counter;
        logic [7:0]  cnt_buf;
        logic        cnt_buf_valid;
        logic [15:0] cap;
        logic        cap_block;
        logic        cap_pend;
        logic [15:0] cmp;
        logic        cmp_block;
        logic        cmp_match;
        logic        cap_flag;
        logic        cmp_flag;
        logic        ovf_flag;
        logic        arm_cap;
        logic        arm_cmp;
        logic        arm_ovf;
        logic        pin;
        logic [7:0]  rdata;
    } tcsf_state_t;

endpackage

// *** design/tcsf_sync_edge.sv ***
`timescale 1ns/1ps
module tcsf_sync_edge (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic pin_async,
    input  wire logic rise_sel,
    output logic      edge_pulse
);
    tcsf_pkg::tcsf_sync_t s_reg;   // synchroniser stages
    tcsf_pkg::tcsf_sync_t s_next;  // next stages

    // shift the pin through two flops, third holds last level
    always_comb begin
        s_next    = s_reg;
        s_next.s1 = pin_async;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // only the second and third stage are compared
    assign edge_pulse = rise_sel ? (s_reg.s2 & ~s_reg.s3)
                                 : (~s_reg.s2 & s_reg.s3);
endmodule

// *** design/tcsf_prescale.sv ***
`timescale 1ns/1ps
module tcsf_prescale (
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          clear,
    output tcsf_pkg::tcsf_phase_t phase
);
    tcsf_pkg::tcsf_phase_t ph_reg;   // current timer state
    tcsf_pkg::tcsf_phase_t ph_next;  // next timer state

    // four states per counter step; clear restarts at t00
    always_comb begin
        case (ph_reg)
            tcsf_pkg::TCSF_T00: ph_next = tcsf_pkg::TCSF_T01;
            tcsf_pkg::TCSF_T01: ph_next = tcsf_pkg::TCSF_T10;
            tcsf_pkg::TCSF_T10: ph_next = tcsf_pkg::TCSF_T11;
            tcsf_pkg::TCSF_T11: ph_next = tcsf_pkg::TCSF_T00;
            default:            ph_next = tcsf_pkg::TCSF_T00;
        endcase
        if (clear) begin
            ph_next = tcsf_pkg::TCSF_T00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ph_reg <= tcsf_pkg::TCSF_T00;
        end else begin
            ph_reg <= ph_next;
        end
    end

    assign phase = ph_reg;
endmodule

// *** design/tcsf_timer.sv ***
`timescale 1ns/1ps
`include "tcsf_cfg.svh"
module tcsf_timer (
    input  wire logic            clk_sys,
    input  wire logic            rst,
    input  tcsf_pkg::tcsf_bus_req_t bus_req,
    output logic [7:0]           bus_rdata,
    input  wire logic            capture_input_pin,
    output logic                 compare_output_pin,
    output logic                 timer_irq
);
    tcsf_pkg::tcsf_state_t s_reg;     // main timer state
    tcsf_pkg::tcsf_state_t s_next;    // next timer state
    tcsf_pkg::tcsf_phase_t phase;     // prescaler state
    logic                  cap_edge;  // qualified capture edge
    logic                  tick;      // last state of a counter step
    logic                  ovf_set;   // counter wraps this cycle
    logic                  cmp_set;   // compare flag rises this cycle
    logic                  cap_set;   // capture flag rises this cycle
    logic                  cnt_clear; // software restarts the counter
    logic                  rd_hit;    // read strobe
    logic                  wr_hit;    // write strobe

    // byte match of a bus address against one offset
    function automatic logic at(input logic [7:0] a, input logic [7:0] ofs);
        at = (a == ofs);
    endfunction

    // counter low byte at either location
    function automatic logic is_cnt_low(input logic [7:0] a);
        is_cnt_low = at(a, `TCSF_OFS_CNTL) || at(a, `TCSF_OFS_ALTL);
    endfunction

    // counter high byte at either location
    function automatic logic is_cnt_high(input logic [7:0] a);
        is_cnt_high = at(a, `TCSF_OFS_CNTH) || at(a, `TCSF_OFS_ALTH);
    endfunction

    assign rd_hit    = bus_req.rd;
    assign wr_hit    = bus_req.wr;
    assign cnt_clear = wr_hit && is_cnt_low(bus_req.addr);

    // capture pin synchroniser and edge polarity
    tcsf_sync_edge u_sync (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .pin_async  (capture_input_pin),
        .rise_sel   (s_reg.ctrl[`TCSF_BIT_EDGE]),
        .edge_pulse (cap_edge)
    );

    // divide-by-four timer state sequence
    tcsf_prescale u_pre (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clear   (cnt_clear),
        .phase   (phase)
    );

    assign tick    = (phase == tcsf_pkg::TCSF_T11);
    assign ovf_set = tick && (s_reg.counter == `TCSF_CNT_MAX);
    assign cmp_set = tick && s_reg.cmp_match;
    assign cap_set = tick && s_reg.cap_pend;

    // next state: counter, capture, compare, bus, flags
    always_comb begin
        s_next       = s_reg;
        s_next.rdata = 8'h00;

        // free-running counter, one step per four clocks
        if (tick) begin
            s_next.counter = s_reg.counter + 16'h0001;
        end

        // comparison sampled only at t01, unless suspended
        if (phase == tcsf_pkg::TCSF_T01 && !s_reg.cmp_block
            && s_reg.cmp == s_reg.counter) begin
            s_next.cmp_match = 1'b1;
        end
        if (tick) begin
            s_next.cmp_match = 1'b0;
        end
        // output latch follows the level bit on each match
        if (cmp_set) begin
            s_next.pin = s_reg.ctrl[`TCSF_BIT_LEVEL];
        end

        // capture pending is consumed at t11
        if (tick) begin
            s_next.cap_pend = 1'b0;
        end
        // transfer on every valid edge, flag set or not
        if (cap_edge && !s_reg.cap_block) begin
            s_next.cap      = s_reg.counter;
            s_next.cap_pend = 1'b1;
        end

        // bus reads, data stands one cycle later
        if (rd_hit) begin
            case (bus_req.addr)
                `TCSF_OFS_CTRL: begin
                    s_next.rdata = s_reg.ctrl & `TCSF_CTRL_MASK;
                end
                `TCSF_OFS_STAT: begin
                    // low five bits always read zero
                    s_next.rdata = {s_reg.cap_flag, s_reg.cmp_flag,
                                    s_reg.ovf_flag, 5'h00};
                    // first step: arm every flag now set
                    s_next.arm_cap = s_reg.cap_flag;
                    s_next.arm_cmp = s_reg.cmp_flag;
                    s_next.arm_ovf = s_reg.ovf_flag;
                end
                `TCSF_OFS_CAPH: begin
                    s_next.rdata     = s_reg.cap[15:8];
                    s_next.cap_block = 1'b1;
                end
                `TCSF_OFS_CAPL: begin
                    s_next.rdata     = s_reg.cap[7:0];
                    s_next.cap_block = 1'b0;
                    if (s_reg.arm_cap) begin
                        s_next.cap_flag = 1'b0;
                    end
                    s_next.arm_cap = 1'b0;
                end
                `TCSF_OFS_CMPH: begin
                    s_next.rdata = s_reg.cmp[15:8];
                end
                `TCSF_OFS_CMPL: begin
                    s_next.rdata = s_reg.cmp[7:0];
                    if (s_reg.arm_cmp) begin
                        s_next.cmp_flag = 1'b0;
                    end
                    s_next.arm_cmp = 1'b0;
                end
                `TCSF_OFS_CNTH, `TCSF_OFS_ALTH: begin
                    s_next.rdata = s_reg.counter[15:8];
                    // freeze low byte only on the first high read
                    if (!s_reg.cnt_buf_valid) begin
                        s_next.cnt_buf       = s_reg.counter[7:0];
                        s_next.cnt_buf_valid = 1'b1;
                    end
                end
                `TCSF_OFS_CNTL: begin
                    s_next.rdata = s_reg.cnt_buf_valid ? s_reg.cnt_buf
                                                       : s_reg.counter[7:0];
                    s_next.cnt_buf_valid = 1'b0;
                    if (s_reg.arm_ovf) begin
                        s_next.ovf_flag = 1'b0;
                    end
                    s_next.arm_ovf = 1'b0;
                end
                `TCSF_OFS_ALTL: begin
                    // same value, but leaves the overflow sequence alone
                    s_next.rdata = s_reg.cnt_buf_valid ? s_reg.cnt_buf
                                                       : s_reg.counter[7:0];
                    s_next.cnt_buf_valid = 1'b0;
                end
                default: begin
                    s_next.rdata = 8'h00; // unmapped reads as zero
                end
            endcase
        end

        // bus writes
        if (wr_hit) begin
            case (bus_req.addr)
                `TCSF_OFS_CTRL: begin
                    s_next.ctrl = bus_req.wdata & `TCSF_CTRL_MASK;
                end
                `TCSF_OFS_STAT: begin
                    // a write also arms overflow clearing
                    s_next.arm_ovf = s_reg.ovf_flag;
                end
                `TCSF_OFS_CMPH: begin
                    s_next.cmp[15:8] = bus_req.wdata;
                    s_next.cmp_block = 1'b1;
                end
                `TCSF_OFS_CMPL: begin
                    s_next.cmp[7:0]  = bus_req.wdata;
                    s_next.cmp_block = 1'b0;
                end
                `TCSF_OFS_CNTL, `TCSF_OFS_ALTL: begin
                    // restart counter; flags and enables untouched
                    s_next.counter       = `TCSF_CNT_RESET;
                    s_next.cnt_buf_valid = 1'b0;
                end
                default: begin
                    // read-only or unmapped: write ignored
                    s_next.ctrl = s_next.ctrl;
                end
            endcase
        end

        // set beats a clear in the same cycle
        if (cap_set) begin
            s_next.cap_flag = 1'b1;
        end
        if (cmp_set) begin
            s_next.cmp_flag = 1'b1;
        end
        if (ovf_set) begin
            s_next.ovf_flag = 1'b1;
        end
    end

    // register update; reset reaches control, counter, blocks, pending, match, arms and read data,
    // capture, compare, flags and pin latch keep their value
    always_ff @(posedge clk_sys) begin
        s_reg <= s_next;
        if (rst) begin
            s_reg.ctrl          <= `TCSF_CTRL_RESET;
            s_reg.counter       <= `TCSF_CNT_RESET;
            s_reg.cnt_buf_valid <= 1'b0;
            s_reg.cap_block     <= 1'b0;
            s_reg.cap_pend      <= 1'b0;
            s_reg.cmp_block     <= 1'b0;
            s_reg.cmp_match     <= 1'b0;
            s_reg.arm_cap       <= 1'b0;
            s_reg.arm_cmp       <= 1'b0;
            s_reg.arm_ovf       <= 1'b0;
            s_reg.rdata         <= 8'h00;
        end
    end

    // outputs
    assign bus_rdata          = s_reg.rdata;
    assign compare_output_pin = s_reg.pin;
    // request stays high while any enabled flag is set
    assign timer_irq = (s_reg.cap_flag & s_reg.ctrl[`TCSF_BIT_CAP_IE])
                     | (s_reg.cmp_flag & s_reg.ctrl[`TCSF_BIT_CMP_IE])
                     | (s_reg.ovf_flag & s_reg.ctrl[`TCSF_BIT_OVF_IE]);

    // checks on the design's own behaviour
    ctrl_reset_a: assert property (@(posedge clk_sys) disable iff (rst)
        $past(rst) |-> (s_reg.ctrl == 8'h01 && s_reg.counter == 16'hfffc))
        else $error("control or counter wrong after reset");

    irq_off_a: assert property (@(posedge clk_sys) disable iff (rst)
        (s_reg.ctrl[7:5] == 3'b000) |-> !timer_irq)
        else $error("interrupt raised with all enables off");

    irq_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        (s_reg.ovf_flag && s_reg.ctrl[5]) |-> timer_irq)
        else $error("enabled overflow flag without interrupt");

    cap_copy_a: assert property (@(posedge clk_sys) disable iff (rst)
        (cap_edge && !s_reg.cap_block) |=> (s_reg.cap == $past(s_reg.counter)))
        else $error("capture did not copy the counter");

    pin_level_a: assert property (@(posedge clk_sys) disable iff (rst)
        (tick && s_reg.cmp_match) |=> (compare_output_pin == $past(s_reg.ctrl[0])))
        else $error("compare pin did not take the level bit");

    stat_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
        (rd_hit && bus_req.addr == 8'h13) |=> (bus_rdata[4:0] == 5'h00))
        else $error("status low bits not zero");

    cap_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
        (cap_edge && !s_reg.cap_block) |-> ##[1:5] s_reg.cap_flag)
        else $error("capture flag late");

    cmp_t01_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(s_reg.cmp_match) |-> ($past(phase) == tcsf_pkg::TCSF_T01))
        else $error("comparison outside t01");

    ovf_wrap_a: assert property (@(posedge clk_sys) disable iff (rst)
        (ovf_set && !cnt_clear) |=> (s_reg.ovf_flag && s_reg.counter == 16'h0000))
        else $error("overflow not flagged on wrap");

    alt_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
        (rd_hit && bus_req.addr == 8'h1b && s_reg.ovf_flag) |=> s_reg.ovf_flag)
        else $error("alternate read cleared overflow");

    ovf_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        (rd_hit && bus_req.addr == 8'h19 && s_reg.arm_ovf && !ovf_set)
        |=> !s_reg.ovf_flag)
        else $error("overflow clear sequence failed");

    cmp_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        s_reg.cmp_block |=> !$rose(s_reg.cmp_match))
        else $error("compare matched while suspended");

    cap_block_a: assert property (@(posedge clk_sys) disable iff (rst)
        (s_reg.cap_block && cap_edge) |=> $stable(s_reg.cap))
        else $error("capture moved while blocked");
endmodule

// *** tb/tcsf_pin_model.sv ***
`timescale 1ns/1ps
// far side of the timer pins: a capture source and a compare sink
module tcsf_pin_model (
    input  wire logic clk_sys,
    input  wire logic compare_output_pin,
    output logic      capture_input_pin
);
    int unsigned n_cmp_edges;   // compare pin transitions seen
    logic        cmp_prev;      // pin level at the previous edge

    // pin idles low at time zero, so the first selected rising edge is ours
    initial begin
        capture_input_pin = 1'b0;
        n_cmp_edges = 0;
    end

    // level change launched after an edge, like a real source
    task automatic set_level(input logic v);
        @(posedge clk_sys);
        capture_input_pin <= v;
    endtask

    // the sink only counts, it never loads the latch back;
    // unknown to unknown after power-up is not a transition
    always @(posedge clk_sys) begin
        if (compare_output_pin !== cmp_prev) begin
            n_cmp_edges <= n_cmp_edges + 1;
        end
        cmp_prev <= compare_output_pin;
    end
endmodule

// *** tb/test_timer_control_status_flags.sv ***
`timescale 1ns/1ps
`include "tcsf_cfg.svh"
module test_timer_control_status_flags;
    // one table row: write, then read back through the mask
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } tcsf_row_t;

    logic                    clk_sys;      // 250 MHz system clock
    logic                    rst;          // synchronous, active high
    tcsf_pkg::tcsf_bus_req_t bus_req;      // register bus request
    logic [7:0]              bus_rdata;    // read data, cycle after rd
    logic                    capture_input_pin;
    logic                    compare_output_pin;
    logic                    timer_irq;
    int                      miscompares;
    int                      n_compared;
    tcsf_row_t               rows [6];

    tcsf_timer u_tcsf_timer (
        .clk_sys            (clk_sys),
        .rst                (rst),
        .bus_req            (bus_req),
        .bus_rdata          (bus_rdata),
        .capture_input_pin  (capture_input_pin),
        .compare_output_pin (compare_output_pin),
        .timer_irq          (timer_irq)
    );

    tcsf_pin_model u_tcsf_pin_model (
        .clk_sys            (clk_sys),
        .compare_output_pin (compare_output_pin),
        .capture_input_pin  (capture_input_pin)
    );

    // clock
    initial clk_sys = 1'b0;
    always #2 clk_sys = ~clk_sys;

    task automatic complete_run;
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // byte compare; flags not yet set stay unknown, so callers mask them out
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        n_compared++;
        if ((got & m) !== (exp & m)) begin
            miscompares++;
            $display("unexpected at %0t: read %h, want %h", $time, got & m, exp & m);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: pin %b, want %b", $time, got, exp);
        end
    endtask

    // one write cycle, then the bus idles for a cycle
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1;
        chk8(bus_rdata, exp, m);
    endtask

    task automatic do_reset;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
    endtask

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        rst = 1'b1;
        bus_req = '0;
        miscompares = 0;
        n_compared = 0;
        rows[0] = '{`TCSF_OFS_CTRL, 8'hff, 8'he3};
        rows[1] = '{`TCSF_OFS_CTRL, 8'h02, 8'h02};
        rows[2] = '{`TCSF_OFS_CMPH, 8'h12, 8'h12};
        rows[3] = '{`TCSF_OFS_CMPL, 8'h34, 8'h34};
        rows[4] = '{8'h20, 8'h55, 8'h00};
        rows[5] = '{`TCSF_OFS_CTRL, 8'h00, 8'h00};
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk(`TCSF_OFS_CTRL, `TCSF_CTRL_RESET, 8'hff);
        chk1(timer_irq, 1'b0);
        $display("test reset done");

        // ordinary register cases
        for (int i = 0; i < 6; i++) begin
            wr_reg(rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].exp, 8'hff);
        end
        rd_chk(`TCSF_OFS_STAT, 8'h00, 8'h1f);
        $display("test table done");

        // compare at 0002 after a restart from fffc: wrap first, match three steps later
        wr_reg(`TCSF_OFS_CMPH, 8'h00);
        wr_reg(`TCSF_OFS_CMPL, 8'h02);
        wr_reg(`TCSF_OFS_CTRL, 8'h01);
        wr_reg(`TCSF_OFS_CNTL, 8'h00);
        repeat (40) @(posedge clk_sys);
        chk1(compare_output_pin, 1'b1);
        rd_chk(`TCSF_OFS_STAT, 8'h60, 8'h60);
        wr_reg(`TCSF_OFS_CTRL, 8'h20);
        #1;
        chk1(timer_irq, 1'b1);
        rd_chk(`TCSF_OFS_ALTL, 8'h00, 8'h00);
        rd_chk(`TCSF_OFS_STAT, 8'h20, 8'h20);
        rd_chk(`TCSF_OFS_CNTL, 8'h00, 8'h00);
        rd_chk(`TCSF_OFS_STAT, 8'h40, 8'h60);
        #1;
        chk1(timer_irq, 1'b0);
        rd_chk(`TCSF_OFS_CMPL, 8'h02, 8'hff);
        rd_chk(`TCSF_OFS_STAT, 8'h00, 8'h60);
        $display("test compare and overflow done");

        // status write arms the overflow clear; level zero drives pin low
        wr_reg(`TCSF_OFS_CTRL, 8'h00);
        wr_reg(`TCSF_OFS_CNTL, 8'h00);
        repeat (40) @(posedge clk_sys);
        chk1(compare_output_pin, 1'b0);
        wr_reg(`TCSF_OFS_STAT, 8'hff);
        rd_chk(`TCSF_OFS_CNTL, 8'h00, 8'h00);
        rd_chk(`TCSF_OFS_STAT, 8'h40, 8'h60);
        rd_chk(`TCSF_OFS_CMPL, 8'h02, 8'hff);
        $display("test status write done");

        // high byte alone suspends compares until the low byte lands
        wr_reg(`TCSF_OFS_CMPH, 8'h00);
        wr_reg(`TCSF_OFS_CTRL, 8'h01);
        wr_reg(`TCSF_OFS_CNTL, 8'h00);
        repeat (40) @(posedge clk_sys);
        chk1(compare_output_pin, 1'b0);
        rd_chk(`TCSF_OFS_STAT, 8'h00, 8'h40);
        wr_reg(`TCSF_OFS_CMPL, 8'h02);
        wr_reg(`TCSF_OFS_CNTL, 8'h00);
        repeat (40) @(posedge clk_sys);
        chk1(compare_output_pin, 1'b1);
        $display("test compare suspend done");

        // capture: rising selected, then falling selected
        wr_reg(`TCSF_OFS_CTRL, 8'h82);
        u_tcsf_pin_model.set_level(1'b1);
        repeat (12) @(posedge clk_sys);
        #1;
        chk1(timer_irq, 1'b1);
        rd_chk(`TCSF_OFS_STAT, 8'h80, 8'h80);
        rd_chk(`TCSF_OFS_CAPL, 8'h00, 8'h00);
        rd_chk(`TCSF_OFS_STAT, 8'h00, 8'h80);
        u_tcsf_pin_model.set_level(1'b0);
        repeat (12) @(posedge clk_sys);
        rd_chk(`TCSF_OFS_STAT, 8'h00, 8'h80);
        wr_reg(`TCSF_OFS_CTRL, 8'h00);
        u_tcsf_pin_model.set_level(1'b1);
        repeat (12) @(posedge clk_sys);
        rd_chk(`TCSF_OFS_STAT, 8'h00, 8'h80);
        u_tcsf_pin_model.set_level(1'b0);
        repeat (12) @(posedge clk_sys);
        rd_chk(`TCSF_OFS_STAT, 8'h80, 8'h80);
        $display("test capture done");

        // reset mid-run leaves the pending capture flag alone
        do_reset();
        rd_chk(`TCSF_OFS_CTRL, `TCSF_CTRL_RESET, 8'hff);
        rd_chk(`TCSF_OFS_STAT, 8'h80, 8'h80);
        // pin went high, low, high: three latch changes in all
        chk8(8'(u_tcsf_pin_model.n_cmp_edges), 8'h03, 8'hff);
        $display("test second reset done");
        complete_run();
    end
endmodule
